// ### src/ris_pkg.sv
package ris_pkg;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] RIS_OFF_CTRL = 8'h00;
  localparam logic [7:0] RIS_OFF_HOLD = 8'h04;
  localparam logic [7:0] RIS_OFF_DAC = 8'h08;
  localparam logic [7:0] RIS_OFF_STATUS = 8'h0C;
  localparam logic [7:0] RIS_OFF_COUNT = 8'h10;

  // ----------------------------------------------------------------
  // control register fields
  // ----------------------------------------------------------------
  localparam int RIS_CTRL_MODE_LSB = 0;
  localparam int RIS_CTRL_EN0 = 4;
  localparam int RIS_CTRL_EN1 = 5;
  localparam int RIS_CTRL_LLDD = 6;
  localparam int RIS_CTRL_TYPE0 = 7;
  localparam int RIS_CTRL_TYPE1 = 8;
  localparam int RIS_CTRL_INV = 9;
  localparam int RIS_CTRL_DIV0_LSB = 12;
  localparam int RIS_CTRL_DIV1_LSB = 14;
  localparam logic [31:0] RIS_CTRL_RESET = 32'h0000_0070;

  // ----------------------------------------------------------------
  // holdover register fields
  // ----------------------------------------------------------------
  localparam int RIS_HOLD_EN = 0;
  localparam int RIS_HOLD_FORCE = 1;
  localparam int RIS_HOLD_TRACK = 2;
  localparam int RIS_HOLD_MANDAC = 3;
  localparam int RIS_HOLD_RAIL = 4;
  localparam int RIS_HOLD_DACDIV_LSB = 16;
  localparam logic [31:0] RIS_HOLD_RESET = 32'h0004_0000;

  localparam int RIS_DAC_W = 10;
  localparam logic [9:0] RIS_DAC_RESET = 10'h200;

  // ----------------------------------------------------------------
  // modes and states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    RIS_MODE_MAN0 = 3'b000,
    RIS_MODE_MAN1 = 3'b001,
    RIS_MODE_PIN = 3'b011,
    RIS_MODE_AUTO = 3'b100,
    RIS_MODE_AUTOPIN = 3'b110
  } ris_mode_t;

  typedef enum logic [1:0] {
    RIS_ST_LOCKED = 2'b00,
    RIS_ST_HOLD = 2'b01,
    RIS_ST_WAIT_LOCK = 2'b10
  } ris_state_t;

endpackage : ris_pkg

// ### src/ris_ref_input_switch_holdover.sv
// Added by the designer: the AHB-Lite interface to the registers and the address map.
module ris_ref_input_switch_holdover
  import ris_pkg::*;
#(
  parameter int DAC_W = RIS_DAC_W
)
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clk_en,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic select_pin_0_in,
  input wire logic select_pin_1_in,
  output logic select_pin_0_oe,
  output logic select_pin_1_oe,
  output logic select_pin_0_out,
  output logic select_pin_1_out,
  input wire logic pll1_lock_detect,
  input wire logic rail_high_cross,
  input wire logic rail_low_cross,
  input wire logic pd_tick,
  input wire logic [DAC_W-1:0] tune_adc,
  output logic [1:0] active_input,
  output logic [1:0] input_buffer_enable,
  output logic [1:0] ref_input_0_div,
  output logic [1:0] ref_input_1_div,
  output logic holdover,
  output logic pll1_charge_pump_output_hiz,
  output logic [DAC_W-1:0] dac_value
);

  // ----------------------------------------------------------------
  // register bus
  // ----------------------------------------------------------------
  logic [31:0] ctrl_q;
  logic [31:0] hold_q;
  logic [DAC_W-1:0] manual_dac_value_q;
  logic [DAC_W-1:0] track_q;
  logic wr_pend_q;
  logic [7:0] wr_addr_q;
  logic [31:0] rdata_d;
  ris_state_t state_q;
  logic active_q;
  logic [15:0] dac_div_cnt_q;

  wire logic xfer = hsel && hready && htrans[1];

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
    end
    else if (clk_en)
    begin
      wr_pend_q <= xfer && hwrite;
      wr_addr_q <= haddr[7:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ctrl_q <= RIS_CTRL_RESET;
      hold_q <= RIS_HOLD_RESET;
      manual_dac_value_q <= DAC_W'(RIS_DAC_RESET);
    end
    else if (clk_en && wr_pend_q)
    begin
      case (wr_addr_q)
        RIS_OFF_CTRL: ctrl_q <= hwdata;
        RIS_OFF_HOLD: hold_q <= hwdata;
        RIS_OFF_DAC: manual_dac_value_q <= hwdata[DAC_W-1:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // field decode
  // ----------------------------------------------------------------
  wire logic [2:0] mode = ctrl_q[RIS_CTRL_MODE_LSB +: 3];
  wire logic [1:0] per_input_enable = {ctrl_q[RIS_CTRL_EN1], ctrl_q[RIS_CTRL_EN0]};
  wire logic lock_loss_detect_disable = ctrl_q[RIS_CTRL_LLDD];
  wire logic [1:0] select_pin_type = {ctrl_q[RIS_CTRL_TYPE1], ctrl_q[RIS_CTRL_TYPE0]};
  wire logic select_pin_polarity_invert = ctrl_q[RIS_CTRL_INV];
  wire logic hold_en = hold_q[RIS_HOLD_EN];
  wire logic force_hold = hold_q[RIS_HOLD_FORCE];
  wire logic track_en = hold_q[RIS_HOLD_TRACK];
  wire logic manual_dac_enable = hold_q[RIS_HOLD_MANDAC];
  wire logic rail_detection_enable = hold_q[RIS_HOLD_RAIL];
  wire logic [15:0] dac_clk_div = hold_q[RIS_HOLD_DACDIV_LSB +: 16];
  wire logic is_auto = (mode == RIS_MODE_AUTO) || (mode == RIS_MODE_AUTOPIN);

  assign ref_input_0_div = ctrl_q[RIS_CTRL_DIV0_LSB +: 2];
  assign ref_input_1_div = ctrl_q[RIS_CTRL_DIV1_LSB +: 2];

  // ----------------------------------------------------------------
  // synchronisers
  // ----------------------------------------------------------------
  logic [2:0] sync1_q;
  logic [2:0] sync2_q;
  logic [2:0] prev_q;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      sync1_q <= 3'h0;
      sync2_q <= 3'h0;
      prev_q <= 3'h0;
    end
    else if (clk_en)
    begin
      sync1_q <= {pll1_lock_detect, select_pin_1_in, select_pin_0_in};
      sync2_q <= sync1_q;
      prev_q <= sync2_q;
    end
  end

  // rail crossing is an analog comparator, treated as asynchronous too
  logic [1:0] rail_s1_q;
  logic [1:0] rail_s2_q;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      rail_s1_q <= 2'h0;
      rail_s2_q <= 2'h0;
    end
    else if (clk_en)
    begin
      rail_s1_q <= {rail_high_cross, rail_low_cross};
      rail_s2_q <= rail_s1_q;
    end
  end

  wire logic lock = sync2_q[2];
  wire logic lock_fell = prev_q[2] && !sync2_q[2];
  // an output-type pin reads as zero
  wire logic [1:0] pins = sync2_q[1:0] & ~select_pin_type;
  wire logic [1:0] pins_prev = prev_q[1:0] & ~select_pin_type;
  wire logic [1:0] pins_auto = select_pin_polarity_invert ? ~pins : pins;
  wire logic rail_hit = rail_detection_enable && (|rail_s2_q);

  assign select_pin_0_oe = select_pin_type[0];
  assign select_pin_1_oe = select_pin_type[1];
  assign select_pin_0_out = holdover;
  assign select_pin_1_out = lock;

  // ----------------------------------------------------------------
  // switch events and target selection
  // ----------------------------------------------------------------
  logic armed_q;
  logic [2:0] mode_prev_q;
  logic event_d;
  logic [1:0] target_d;
  logic pin_hold_d;

  always_comb
  begin
    event_d = 1'b0;
    target_d = {1'b0, active_q};
    pin_hold_d = 1'b0;
    case (mode)
      RIS_MODE_MAN0, RIS_MODE_MAN1:
      begin
        target_d = {1'b0, mode[0]};
        event_d = lock_fell && !lock_loss_detect_disable;
      end
      RIS_MODE_PIN:
      begin
        // host is expected to set lock-loss disable here
        event_d = (pins != pins_prev) || (lock_fell && !lock_loss_detect_disable);
        case (pins)
          2'b00: target_d = 2'b00;
          2'b01: target_d = 2'b01;
          2'b11: pin_hold_d = 1'b1;
          default: target_d = {1'b0, active_q};
        endcase
      end
      RIS_MODE_AUTO:
      begin
        event_d = armed_q && lock_fell && !lock_loss_detect_disable;
        if (per_input_enable[~active_q])
          target_d = {1'b0, ~active_q};
      end
      RIS_MODE_AUTOPIN:
      begin
        event_d = armed_q && lock_fell;
        if (pins_auto[0])
          target_d = 2'b00;
        else if (pins_auto[1])
          target_d = 2'b01;
      end
      default: ;
    endcase
  end

  // ----------------------------------------------------------------
  // active input and holdover state
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      mode_prev_q <= 3'h0;
    else if (clk_en)
      mode_prev_q <= mode;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      armed_q <= 1'b1;
    else if (clk_en)
    begin
      if (event_d)
        armed_q <= 1'b0;
      else if (lock)
        armed_q <= 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      active_q <= 1'b0;
      state_q <= RIS_ST_LOCKED;
    end
    else if (clk_en)
    begin
      if (force_hold || rail_hit || (mode == RIS_MODE_PIN && pin_hold_d))
        state_q <= RIS_ST_HOLD;
      else if (is_auto && mode != mode_prev_q && lock)
        active_q <= active_q;
      else if (event_d)
      begin
        if (hold_en)
        begin
          state_q <= RIS_ST_HOLD;
          if (is_auto)
            active_q <= target_d[0];
        end
        else
          active_q <= target_d[0];
      end
      else
      begin
        case (state_q)
          RIS_ST_HOLD:
            if (!hold_en)
              state_q <= RIS_ST_LOCKED;
            else if (!lock)
              state_q <= RIS_ST_WAIT_LOCK;
          RIS_ST_WAIT_LOCK:
            if (lock || !hold_en)
            begin
              state_q <= RIS_ST_LOCKED;
              if (!is_auto)
                active_q <= target_d[0];
            end
          default:
            if (!is_auto)
              active_q <= target_d[0];
        endcase
      end
    end
  end

  assign holdover = (state_q != RIS_ST_LOCKED);
  assign pll1_charge_pump_output_hiz = holdover;
  assign active_input = {1'b0, active_q};
  // manual and pin modes keep the chosen buffer running
  assign input_buffer_enable = per_input_enable |
    ((mode == RIS_MODE_MAN0 || mode == RIS_MODE_MAN1 || mode == RIS_MODE_PIN) ?
     (active_q ? 2'b10 : 2'b01) : 2'b00);

  // ----------------------------------------------------------------
  // dac tracking
  // ----------------------------------------------------------------
  // tracking is refused while rail detection is on, since that mode is invalid
  wire logic tracking = track_en && !manual_dac_enable && !rail_detection_enable;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      dac_div_cnt_q <= 16'h0000;
      track_q <= '0;
    end
    else if (clk_en && track_en && pd_tick && !holdover)
    begin
      if (dac_div_cnt_q + 16'h0001 >= dac_clk_div)
      begin
        dac_div_cnt_q <= 16'h0000;
        track_q <= tune_adc;
      end
      else
        dac_div_cnt_q <= dac_div_cnt_q + 16'h0001;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      dac_value <= DAC_W'(RIS_DAC_RESET);
    else if (clk_en)
      dac_value <= tracking ? track_q : manual_dac_value_q;
  end

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------
  always_comb
  begin
    case (haddr[7:0])
      RIS_OFF_CTRL: rdata_d = ctrl_q;
      RIS_OFF_HOLD: rdata_d = hold_q;
      RIS_OFF_DAC: rdata_d = 32'(manual_dac_value_q);
      RIS_OFF_STATUS: rdata_d = {26'h0, lock, holdover, state_q, 1'b0, active_q};
      RIS_OFF_COUNT: rdata_d = track_en ? 32'(track_q) : 32'h0000_0000;
      default: rdata_d = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata <= 32'h0000_0000;
    else if (clk_en && xfer && !hwrite)
      hrdata <= rdata_d;
  end

endmodule // ris_ref_input_switch_holdover

// ### verification/ris_chk.sv
module ris_chk
  import ris_pkg::*;
#(
  parameter int DAC_W = RIS_DAC_W
)
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clk_en,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic select_pin_0_in,
  input wire logic pll1_lock_detect,
  input wire logic [1:0] active_input,
  input wire logic holdover,
  input wire logic pll1_charge_pump_output_hiz,
  input wire logic [DAC_W-1:0] dac_value
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  // ------------------------------------------------
  // properties
  // ------------------------------------------------
  // a register write just before would hide the synchroniser delay
  sequence s_quiet;
    (!hsel && clk_en) [*3];
  endsequence
  property p_pin_sync;
    s_quiet ##0 $changed(select_pin_0_in) |=> $stable(active_input) [*2];
  endproperty
  a_pin_sync: assert property (p_pin_sync) else $error("pin acted too early");
  property p_lock_sync;
    s_quiet ##0 $fell(pll1_lock_detect) |=> $stable(holdover) [*2];
  endproperty
  a_lock_sync: assert property (p_lock_sync) else $error("lock acted too early");
  property p_hiz;
    pll1_charge_pump_output_hiz == holdover;
  endproperty
  a_hiz: assert property (p_hiz) else $error("pump not tied to holdover");
  property p_okay;
    hreadyout && !hresp;
  endproperty
  a_okay: assert property (p_okay) else $error("bus stalled or erred");
  property p_act;
    active_input[1] == 1'b0;
  endproperty
  a_act: assert property (p_act) else $error("active input out of range");
  property p_frz;
    !clk_en |=> $stable(active_input) && $stable(holdover) && $stable(hrdata);
  endproperty
  a_frz: assert property (p_frz) else $error("state moved while frozen");
  property p_rst;
    $rose(hresetn) |-> dac_value == RIS_DAC_RESET && !holdover && active_input == 2'h0;
  endproperty
  a_rst: assert property (p_rst) else $error("bad state after reset");
  property p_rdata;
    $changed(hrdata) |-> $past(hsel && htrans[1] && !hwrite && hready && clk_en);
  endproperty
  a_rdata: assert property (p_rdata) else $error("read data moved without read");
endmodule // ris_chk

bind ris_ref_input_switch_holdover ris_chk #(.DAC_W(DAC_W)) u_chk (
  .hclk, .hresetn, .clk_en, .hsel, .htrans, .hwrite, .hready, .hrdata, .hreadyout,
  .hresp, .select_pin_0_in, .pll1_lock_detect, .active_input, .holdover,
  .pll1_charge_pump_output_hiz, .dac_value
);

// ### verification/ris_host_pins.sv
module ris_host_pins
(
  input wire logic hclk,
  input wire logic [1:0] want,
  input wire logic [1:0] oe,
  input wire logic [1:0] dev_out,
  output logic [1:0] pin
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] lvl_q;
  // the host moves its select pins only just after a clock edge
  always_ff @(posedge hclk)
  begin
    lvl_q <= want;
  end
  // where the device drives a pin its level wins
  assign pin = (oe & dev_out) | (~oe & lvl_q);
endmodule // ris_host_pins

// ### verification/tb_top.sv
module tb_top
  import ris_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic hclk, hresetn, clk_en, hsel, hwrite, hready, lock, pd_tick, rail_hi;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans, want, pin, oe, dout, act, bufen, div0, div1;
  logic [2:0] hsize;
  logic [9:0] tune, dac;
  logic hreadyout, hresp, hov, hiz;
  int mismatches, total_checks;

  ris_ref_input_switch_holdover i_dut (
    .hclk, .hresetn, .clk_en, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready, .hrdata, .hreadyout, .hresp,
    .select_pin_0_in(pin[0]), .select_pin_1_in(pin[1]),
    .select_pin_0_oe(oe[0]), .select_pin_1_oe(oe[1]),
    .select_pin_0_out(dout[0]), .select_pin_1_out(dout[1]),
    .pll1_lock_detect(lock), .rail_high_cross(rail_hi), .rail_low_cross(1'b0),
    .pd_tick, .tune_adc(tune), .active_input(act), .input_buffer_enable(bufen),
    .ref_input_0_div(div0), .ref_input_1_div(div1), .holdover(hov),
    .pll1_charge_pump_output_hiz(hiz), .dac_value(dac)
  );
  ris_host_pins i_host (.hclk, .want, .oe, .dev_out(dout), .pin);

  // the one slave's ready is the bus's ready
  assign hready = hreadyout;

  initial
  begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end

  // ------------------------------------------------
  // shared tasks
  // ------------------------------------------------
  task automatic w(input int n);
    repeat (n) @(posedge hclk);
  endtask

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e)
    begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic look(input logic [1:0] a, input logic h);
    chk("active_input", 32'(a), 32'(act));
    chk("holdover", 32'(h), 32'(hov));
  endtask

  task automatic bus(input logic wt, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] r);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wt;
    haddr <= {24'h00, a};
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    r = hrdata;
  endtask

  // settling time keeps later pin and lock moves clear of the write
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
    w(6);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string n);
    logic [31:0] r;
    bus(1'b0, a, 32'h0, r);
    chk(n, e, r);
  endtask

  task automatic pins(input logic [1:0] v);
    @(posedge hclk);
    want <= v;
    w(8);
  endtask

  task automatic lk(input logic v);
    @(posedge hclk);
    lock <= v;
    w(8);
  endtask

  // ------------------------------------------------
  // scenarios
  // ------------------------------------------------
  task automatic t_reset();
    rd(RIS_OFF_CTRL, RIS_CTRL_RESET, "ctrl");
    rd(RIS_OFF_HOLD, RIS_HOLD_RESET, "hold");
    rd(RIS_OFF_DAC, 32'(RIS_DAC_RESET), "dac_reg");
    wr(8'h14, 32'hFFFF_FFFF);
    rd(8'h14, 32'h0, "unmapped");
    look(2'h0, 1'b0);
    chk("dac_value", 32'(RIS_DAC_RESET), 32'(dac));
    @(posedge hclk);
    clk_en <= 1'b0;
    w(3);
    clk_en <= 1'b1;
    $display("t_reset done");
  endtask

  task automatic t_manual();
    wr(RIS_OFF_CTRL, 32'h0000_B051);
    look(2'h1, 1'b0);
    chk("buffer_1", 32'h1, 32'(bufen[1]));
    chk("div0", 32'h3, 32'(div0));
    chk("div1", 32'h2, 32'(div1));
    wr(RIS_OFF_CTRL, 32'h0000_1010);
    look(2'h0, 1'b0);
    chk("div0", 32'h1, 32'(div0));
    wr(RIS_OFF_HOLD, 32'h0004_0001);
    lk(1'b0);
    look(2'h0, 1'b1);
    chk("hiz", 32'h1, 32'(hiz));
    lk(1'b1);
    look(2'h0, 1'b0);
    $display("t_manual done");
  endtask

  task automatic t_pin();
    wr(RIS_OFF_HOLD, RIS_HOLD_RESET);
    wr(RIS_OFF_CTRL, 32'h0000_0043);
    pins(2'b01);
    look(2'h1, 1'b0);
    chk("buffer_1", 32'h1, 32'(bufen[1]));
    pins(2'b11);
    chk("holdover", 32'h1, 32'(hov));
    pins(2'b00);
    look(2'h0, 1'b0);
    wr(RIS_OFF_CTRL, 32'h0000_0143);
    chk("pin_oe", 32'h2, 32'(oe));
    pins(2'b11);
    look(2'h1, 1'b0);
    pins(2'b00);
    wr(RIS_OFF_CTRL, 32'h0000_0043);
    wr(RIS_OFF_HOLD, 32'h0004_0001);
    pins(2'b01);
    chk("holdover", 32'h1, 32'(hov));
    lk(1'b0);
    lk(1'b1);
    look(2'h1, 1'b0);
    $display("t_pin done");
  endtask

  task automatic t_auto();
    wr(RIS_OFF_CTRL, 32'h0000_0050);
    wr(RIS_OFF_CTRL, 32'h0000_0014);
    look(2'h0, 1'b0);
    lk(1'b0);
    look(2'h0, 1'b1);
    lk(1'b1);
    wr(RIS_OFF_CTRL, 32'h0000_0034);
    look(2'h0, 1'b0);
    lk(1'b0);
    look(2'h1, 1'b1);
    lk(1'b1);
    look(2'h1, 1'b0);
    wr(RIS_OFF_DAC, 32'h0000_00AB);
    wr(RIS_OFF_HOLD, 32'h0004_000B);
    look(2'h1, 1'b1);
    chk("dac_value", 32'h0000_00AB, 32'(dac));
    wr(RIS_OFF_HOLD, RIS_HOLD_RESET);
    $display("t_auto done");
  endtask

  task automatic t_apin();
    wr(RIS_OFF_CTRL, 32'h0000_0076);
    lk(1'b0);
    look(2'h0, 1'b0);
    lk(1'b1);
    wr(RIS_OFF_CTRL, 32'h0000_0276);
    lk(1'b0);
    look(2'h1, 1'b0);
    lk(1'b1);
    $display("t_apin done");
  endtask

  task automatic t_track();
    wr(RIS_OFF_HOLD, 32'h0001_0004);
    repeat (16)
    begin
      @(posedge hclk);
      pd_tick <= 1'b1;
      @(posedge hclk);
      pd_tick <= 1'b0;
    end
    w(4);
    rd(RIS_OFF_COUNT, 32'h0000_0155, "count");
    chk("dac_value", 32'h0000_0155, 32'(dac));
    $display("t_track done");
  endtask

  // a rail crossing holds the loop until lock drops and recovers
  task automatic t_rail();
    wr(RIS_OFF_HOLD, 32'h0004_0011);
    @(posedge hclk);
    rail_hi <= 1'b1;
    w(6);
    chk("holdover", 32'h1, 32'(hov));
    chk("dac_value", 32'h0000_00AB, 32'(dac));
    @(posedge hclk);
    rail_hi <= 1'b0;
    lk(1'b0);
    lk(1'b1);
    look(2'h1, 1'b0);
    $display("t_rail done");
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // the tests need about 420 cycles; this is some 48 times that
  initial
  begin
    #1ms;
    mismatches++;
    stop_test();
  end

  initial
  begin
    hresetn = 1'b0;
    clk_en = 1'b1;
    hsel = 1'b0;
    hwrite = 1'b0;
    rail_hi = 1'b0;
    lock = 1'b1;
    pd_tick = 1'b0;
    haddr = 32'h0;
    hwdata = 32'h0;
    htrans = 2'h0;
    hsize = 3'h2;
    want = 2'h0;
    tune = 10'h155;
    w(2);
    hresetn <= 1'b1;
    t_reset();
    t_manual();
    t_pin();
    t_auto();
    t_apin();
    t_track();
    t_rail();
    stop_test();
  end
endmodule // tb_top
